// file: rtl/local_bus_defs.svh
// Summary of operation
// [R1] Drive 21-bit address for every bus cycle.
// [R2] Drive data on writes, sample on reads.
// [R3] Upper-lane enable with address LSB encodes lanes.
// [R4] Read strobe low throughout each read cycle.
// [R5] Write strobe low throughout each write cycle.
// [R6] Low wait input adds one wait state each; the code adds at most one per bus cycle.
// [R7] LAN select low only for LAN controller cycles.
// [R8] LAN controller raises interrupt when it has data.
// [R9] Wait input held high when unused.
`ifndef LOCAL_BUS_DEFS_SVH
`define LOCAL_BUS_DEFS_SVH
`define LB_ADDR_W   21
`define LB_DATA_W   16
`define LB_STROBE_CYCLES 2'h2
`define LB_SIZE_WORD 2'h0
`define LB_SIZE_EVEN 2'h1
`define LB_SIZE_ODD  2'h2
`endif

// file: rtl/local_bus_master_port.sv
`include "local_bus_defs.svh"
module local_bus_master_port
  import local_bus_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire lb_req_s               req,
  output logic                       rsp_valid,
  output logic [`LB_DATA_W-1:0]      rsp_rdata,
  output logic [`LB_ADDR_W-1:0]      addr_out,
  output logic                       upper_lane_enable_n,
  input  wire logic [`LB_DATA_W-1:0] data_in,
  output logic [`LB_DATA_W-1:0]      data_out,
  output logic                       data_oe,
  output logic                       rd_n,
  output logic                       wr_n,
  input  wire logic                  wait_n,
  output logic                       lan_select_n,
  input  wire logic                  lan_irq,
  output logic                       lan_irq_sync
);

  // Engine state and the attributes of the cycle in flight. They are kept
  // apart from the pins so that the release logic needs no decoding of them.
  lb_state_e         state_reg;     // Bus engine state.
  logic [1:0]        cnt_reg;       // Strobe cycles left.
  logic              wait_meta_reg; // First synchroniser stage for the wait pin.
  logic              wait_n_reg;    // Synchronised wait pin.
  logic              irq_meta_reg;  // First synchroniser stage for the interrupt pin.
  logic              write_reg;     // Current cycle is a write.
  logic              waited_reg;    // A wait state was already inserted this cycle.
  logic              word_reg;      // Current cycle is a word transfer.

  // Lane encoding: an odd address can only ever carry a single byte,
  // so the both-high combination is never produced.
  function automatic logic lane_n(input logic word, input logic lsb);
    lane_n = !(word || lsb);
  endfunction : lane_n

  // The core may offer a request only while the engine is idle. A request
  // offered at any other time is not taken, so the core must hold it.
  assign req_ready = (state_reg == ST_IDLE);

  // External pins are asynchronous to clk, so both pass two flops.
  // A wait request shorter than two clocks may be missed; a slow device must hold it.
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_meta_reg <= 1'b1;
      wait_n_reg    <= 1'b1;
      irq_meta_reg  <= 1'b0;
      lan_irq_sync  <= 1'b0;
    end else begin
      wait_meta_reg <= wait_n;
      wait_n_reg    <= wait_meta_reg;
      irq_meta_reg  <= lan_irq;
      lan_irq_sync  <= irq_meta_reg; // [R8]
    end
  end

  // State sequencing: strobe for a fixed count, plus one wait state if asked.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 2'h0;
      waited_reg <= 1'b0;
    end else begin
      case (state_reg)
        // Accept a request and load the fixed strobe count.
        ST_IDLE: begin
          if (req_valid) begin
            state_reg  <= ST_STROBE;
            cnt_reg    <= `LB_STROBE_CYCLES;
            waited_reg <= 1'b0;
          end
        end
        // Count down, then either insert the single wait state or finish.
        ST_STROBE: begin
          if (cnt_reg > 2'h1) begin
            cnt_reg <= cnt_reg - 2'h1;
          end else if (!wait_n_reg && !waited_reg) begin
            state_reg  <= ST_WAIT; // [R6]
            waited_reg <= 1'b1;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          // The single inserted wait state ends the cycle next.
          state_reg <= ST_IDLE; // [R6]
        end
        // An illegal state code falls back to idle rather than hanging the bus.
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin outputs: address, lanes, data and strobes are registered.
  // Registered strobes cannot glitch, at the cost of one cycle of latency.
  // Address and lane code stand until the next request is taken.
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_out            <= '0;
      upper_lane_enable_n <= 1'b1;
      data_out            <= '0;
      data_oe             <= 1'b0;
      rd_n                <= 1'b1;
      wr_n                <= 1'b1;
      lan_select_n        <= 1'b1;
      write_reg           <= 1'b0;
      word_reg            <= 1'b0;
    end else if (state_reg == ST_IDLE && req_valid) begin
      addr_out            <= req.addr;                         // [R1]
      upper_lane_enable_n <= lane_n(req.word, req.addr[0]);    // [R3]
      data_out            <= req.addr[0] ? {req.wdata[7:0], 8'h00} : req.wdata; // [R2]
      data_oe             <= req.write;                        // [R2]
      rd_n                <= req.write;                        // [R4]
      wr_n                <= !req.write;                       // [R5]
      lan_select_n        <= !req.lan;                         // [R7]
      write_reg           <= req.write;
      word_reg            <= req.word && !req.addr[0];
    end else if ((state_reg == ST_STROBE && cnt_reg <= 2'h1 &&
                  (wait_n_reg || waited_reg)) || state_reg == ST_WAIT) begin
      rd_n         <= 1'b1; // [R4]
      wr_n         <= 1'b1; // [R5]
      data_oe      <= 1'b0;
      lan_select_n <= 1'b1; // [R7]
    end
  end

  // Read data is sampled at the edge that releases the read strobe, and the
  // response pulses in the cycle that follows that edge. The data pins are
  // held stable by the far side for the whole strobe, so one flop suffices.
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= !rd_n && !rsp_valid && ((state_reg == ST_STROBE && cnt_reg <= 2'h1 &&
                   (wait_n_reg || waited_reg)) || state_reg == ST_WAIT);
      if (!rd_n && (state_reg == ST_WAIT || (state_reg == ST_STROBE && cnt_reg <= 2'h1)))
        rsp_rdata <= word_reg ? data_in :
                     (addr_out[0] ? {8'h00, data_in[15:8]} : {8'h00, data_in[7:0]}); // [R2]
    end
  end

  // Checks on the pin behaviour.
  // All of them are sampled on clk and are quiet while reset is high.
  // The unused lane code must never reach the pins.
  property p_lane_legal;
    @(posedge clk) disable iff (rst) !(upper_lane_enable_n && addr_out[0]);
  endproperty
  a_lane_legal: assert property (p_lane_legal) else $error("illegal lane code"); // [R3]

  // A cycle is either a read or a write, never both.
  property p_not_both;
    @(posedge clk) disable iff (rst) !(!rd_n && !wr_n);
  endproperty
  a_not_both: assert property (p_not_both) else $error("both strobes low"); // [R4]

  // An idle engine leaves both strobes inactive.
  property p_rd_idle;
    @(posedge clk) disable iff (rst) (state_reg == ST_IDLE) |-> rd_n && wr_n;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("strobe low while idle"); // [R4] [R5]

  // Every accepted request gives at least the fixed strobe length.
  property p_strobe_len;
    @(posedge clk) disable iff (rst) (req_ready && req_valid) |=> (!rd_n || !wr_n) [*2];
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe too short"); // [R4]

  // A held wait request adds exactly one state before the cycle ends.
  property p_wait_adds;
    @(posedge clk) disable iff (rst)
      (state_reg == ST_STROBE && cnt_reg == 2'h1 && !wait_n_reg && !waited_reg)
      |=> state_reg == ST_WAIT ##1 state_reg == ST_IDLE;
  endproperty
  a_wait_adds: assert property (p_wait_adds) else $error("wait state missing"); // [R6]

  // The LAN select never stands outside a strobe.
  property p_lan_cs;
    @(posedge clk) disable iff (rst) !lan_select_n |-> (!rd_n || !wr_n);
  endproperty
  a_lan_cs: assert property (p_lan_cs) else $error("lan select outside cycle"); // [R7]

  // The data pins are driven only during a write strobe.
  property p_oe_write;
    @(posedge clk) disable iff (rst) data_oe |-> !wr_n;
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("data driven off write"); // [R2]

  // The address stands for the whole read strobe.
  property p_addr_hold;
    @(posedge clk) disable iff (rst) (!rd_n && $past(!rd_n)) |-> $stable(addr_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle"); // [R1]

  // A read answer is a single pulse, so the core cannot take one word twice.
  property p_rsp_pulse;
    @(posedge clk) disable iff (rst) rsp_valid |=> !rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("response too long"); // [R2]

  // The answer comes only as a read strobe is released.
  property p_rsp_read;
    @(posedge clk) disable iff (rst) rsp_valid |-> $rose(rd_n);
  endproperty
  a_rsp_read: assert property (p_rsp_read) else $error("response without read"); // [R4]

  // With the wait pin high the strobe ends after its fixed count.
  property p_no_wait;
    @(posedge clk) disable iff (rst)
      (state_reg == ST_STROBE && cnt_reg == 2'h1 && wait_n_reg) |=> state_reg == ST_IDLE;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("wait state not asked for"); // [R6]

  // Main scenarios: reads, writes, wait states, LAN cycles and odd-lane reads.
  c_read:  cover property (@(posedge clk) disable iff (rst) $fell(rd_n));
  c_odd:   cover property (@(posedge clk) disable iff (rst) $fell(rd_n) && addr_out[0]);
  c_write: cover property (@(posedge clk) disable iff (rst) $fell(wr_n));
  c_wait:  cover property (@(posedge clk) disable iff (rst) state_reg == ST_WAIT);
  c_lan:   cover property (@(posedge clk) disable iff (rst) $fell(lan_select_n));

endmodule : local_bus_master_port

// file: rtl/local_bus_pkg.sv
`include "local_bus_defs.svh"
package local_bus_pkg;
  // One request from the device core to the bus engine.
  typedef struct packed {
    logic [`LB_ADDR_W-1:0] addr;  // Byte address; bit 0 selects the odd lane.
    logic [`LB_DATA_W-1:0] wdata; // Write data, placed on the matching lane.
    logic                  write; // High for a write cycle.
    logic                  word;  // High for a 16-bit transfer.
    logic                  lan;   // High when the cycle targets the LAN controller.
  } lb_req_s;

  // Bus engine states.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_STROBE = 3'b010,
    ST_WAIT   = 3'b100
  } lb_state_e;
endpackage : local_bus_pkg

// file: verification/far_side_model.sv
module far_side_model (
  input  wire logic [20:0] addr_out,
  input  wire logic        rd_n,
  input  wire logic        slow,
  input  wire logic        irq_on,
  output logic      [15:0] data_in,
  output logic             wait_n,
  output logic             lan_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] pat; // Stored word, a fixed function of the address.

  // Released bus shows the inverse, so a late sample cannot pass.
  assign pat     = addr_out[15:0] ^ 16'h5a5a;
  assign data_in = rd_n ? ~pat : pat;
  // A slow device pulls wait low, else the pull-up keeps it high.
  assign wait_n  = ~slow;
  assign lan_irq = irq_on;
endmodule : far_side_model

// file: verification/test_local_bus_master_port.sv
module test_local_bus_master_port
  import local_bus_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, req_valid, req_ready, rsp_valid, upper_lane_enable_n, data_oe;
  logic rd_n, wr_n, wait_n, lan_select_n, lan_irq, lan_irq_sync, slow, irq_on;
  lb_req_s     req;
  logic [15:0] rsp_rdata, data_in, data_out;
  logic [20:0] addr_out;
  int          err_total, checks, cyc;

  local_bus_master_port i_local_bus_master_port (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .addr_out(addr_out), .upper_lane_enable_n(upper_lane_enable_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .rd_n(rd_n), .wr_n(wr_n),
    .wait_n(wait_n), .lan_select_n(lan_select_n), .lan_irq(lan_irq),
    .lan_irq_sync(lan_irq_sync));
  far_side_model i_far_side_model (.addr_out(addr_out), .rd_n(rd_n), .slow(slow),
    .irq_on(irq_on), .data_in(data_in), .wait_n(wait_n), .lan_irq(lan_irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task chk(input logic [20:0] g, input logic [20:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task test_done();
    $display("mismatches %0d of %0d compares", err_total, checks);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  // Cut a hang short; the full run needs under a hundred cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      test_done();
    end
  end

  // One whole bus cycle, checked at the pins and at the response.
  task xfer(input logic wr, wd, ln, input logic [20:0] a, input logic [15:0] w, input int ns);
    int          n;
    logic [15:0] p;
    while (req_ready !== 1'b1) @(posedge clk) #1;
    req = '{addr: a, wdata: w, write: wr, word: wd, lan: ln};
    req_valid = 1'b1;
    @(posedge clk) #1 req_valid = 1'b0;
    chk(addr_out, a);
    chk(upper_lane_enable_n, !(wd || a[0]));
    chk(lan_select_n, !ln);
    chk(rd_n, wr);
    chk(wr_n, !wr);
    chk(data_oe, wr);
    chk(req_ready, 1'b0);
    if (wr) chk(a[0] ? data_out[15:8] : data_out[7:0], w[7:0]);
    if (wr && wd && !a[0]) chk(data_out, w);
    n = 0;
    while ((wr ? wr_n : rd_n) === 1'b0 && n < 9) begin
      n++;
      @(posedge clk) #1;
    end
    chk(21'(n), 21'(ns));
    chk(lan_select_n, 1'b1);
    // The read answer pulses in the cycle in which the strobe is released.
    chk(rsp_valid, !wr);
    if (!wr) begin
      p = a[15:0] ^ 16'h5a5a;
      chk(rsp_rdata, (wd && !a[0]) ? p : a[0] ? {8'h00, p[15:8]} : {8'h00, p[7:0]});
    end
  endtask : xfer

  // Every lane code, read and write, to memory and to the LAN chip.
  task t_lanes();
    for (int i = 0; i < 8; i++) begin
      xfer(i[0], i[1], i[2], {i[2], 19'h2b3c5, i[1] & (i[0] ^ i[2])},
           16'hc3a1 + 16'(i), 2);
    end
  endtask : t_lanes

  // Held wait adds exactly one state to each cycle.
  task t_wait();
    slow = 1'b1;
    repeat (4) @(posedge clk) #1;
    xfer(1'b0, 1'b1, 1'b0, 21'h1ffffe, 16'h0000, 3);
    xfer(1'b1, 1'b0, 1'b1, 21'h000001, 16'h00e7, 3);
    slow = 1'b0;
    repeat (4) @(posedge clk) #1;
    xfer(1'b0, 1'b0, 1'b0, 21'h000010, 16'h0000, 2);
  endtask : t_wait

  task t_irq();
    irq_on = 1'b1;
    repeat (3) @(posedge clk) #1;
    chk(lan_irq_sync, 1'b1);
    irq_on = 1'b0;
    repeat (3) @(posedge clk) #1;
    chk(lan_irq_sync, 1'b0);
  endtask : t_irq

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    slow = 1'b0;
    irq_on = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    chk({rd_n, wr_n, lan_select_n, upper_lane_enable_n, data_oe, rsp_valid, req_ready},
        7'h79);
    chk(addr_out, 21'h000000);
    t_lanes();
    t_wait();
    t_irq();
    test_done();
  end
endmodule : test_local_bus_master_port
